// file: tb.sv
// Testbench: reader and tag joined, plus a raw driver on a second tag.
// Assumes the package, interface and both ends are compiled first.
`timescale 1ns/1ps
module tb;
	localparam logic [127:0] WB  = 128'hDDCC_BBAA_9988_7766_5544_3322_1100_FFEE;
	localparam logic [31:0]  WB2 = 32'h0F1E_2D3C;
	localparam logic [31:0]  WP  = 32'h4433_2211;
	logic                clk = 1'b0;
	logic                reset_n = 1'b0;
	logic [31:0]         uid = 32'hA5C3_0F96;
	logic                go_init = 1'b0;
	logic                go_select = 1'b0;
	logic                req_valid = 1'b0;
	logic                req_ready;
	logic [3:0]          req_code = 4'h0;
	logic [7:0]          req_page_address = 8'h00;
	logic [127:0]        req_wdata = '0;
	logic                rsp_stall = 1'b0;
	logic                done;
	logic                done_ok;
	logic [127:0]        done_data;
	tmch_pkg::tmch_tst_t st1;
	tmch_pkg::tmch_tst_t st2;
	logic                busy1;
	logic                busy2;
	logic                ok;
	logic [127:0]        rd;
	logic [15:0]         got[$];
	int                  n_fail = 0;
	int                  total_checks = 0;
	tmch_link_if link ();
	tmch_link_if link_x ();
	tmch_tag tmch_tag_i (.clk(clk), .reset_n(reset_n), .link(link),
		.uid(uid), .go_init(go_init), .go_select(go_select),
		.tag_state(st1), .busy(busy1));
	tmch_reader tmch_reader_i (.clk(clk), .reset_n(reset_n), .link(link),
		.req_valid(req_valid), .req_ready(req_ready), .req_code(req_code),
		.req_page_address(req_page_address), .req_uid(uid),
		.req_wdata(req_wdata), .rsp_stall(rsp_stall), .done(done),
		.done_ok(done_ok), .done_data(done_data));
	tmch_asserts tmch_asserts_i (.clk(clk), .reset_n(reset_n),
		.cmd_valid(link.cmd_valid), .cmd_ready(link.cmd_ready),
		.cmd_data(link.cmd_data), .cmd_last(link.cmd_last),
		.rsp_valid(link.rsp_valid), .rsp_ready(link.rsp_ready),
		.rsp_kind(link.rsp_kind), .rsp_data(link.rsp_data),
		.rsp_last(link.rsp_last));
	// Second tag faces the raw driver, so frames can be broken on purpose
	tmch_tag tmch_tag_x_i (.clk(clk), .reset_n(reset_n), .link(link_x),
		.uid(uid), .go_init(go_init), .go_select(go_select),
		.tag_state(st2), .busy(busy2));
	always #10 clk = ~clk;
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [127:0] e,
		input logic [127:0] g);
		total_checks++;
		if (g !== e) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic give_up(input string nm);
		n_fail++;
		$display("[FAIL] %s expected handshake seen none", nm);
		report_and_stop();
	endtask
	function automatic logic [7:0] crc_f(input logic [7:0] q[$]);
		logic [7:0] c;
		c = 8'hFF;
		foreach (q[i]) begin
			c ^= q[i];
			repeat (8) c = c[7] ? {c[6:0], 1'b0} ^ 8'h1D : {c[6:0], 1'b0};
		end
		return c;
	endfunction
	task automatic do_reset();
		@(posedge clk);
		reset_n <= 1'b0;
		repeat (2) @(posedge clk);
		reset_n <= 1'b1;
	endtask
	task automatic pulse(input bit sel);
		@(posedge clk);
		if (sel)
			go_select <= 1'b1;
		else
			go_init <= 1'b1;
		@(posedge clk);
		go_select <= 1'b0;
		go_init <= 1'b0;
	endtask
	// One user request; stall holds answers off for that many cycles
	task automatic req(input logic [3:0] c, input logic [7:0] a,
		input logic [127:0] w, input int stall);
		int k;
		@(posedge clk);
		req_valid <= 1'b1;
		req_code <= c;
		req_page_address <= a;
		req_wdata <= w;
		k = 0;
		@(negedge clk);
		while (req_ready !== 1'b1) begin
			if (++k > 2000)
				give_up("req_ready");
			@(negedge clk);
		end
		@(posedge clk);
		req_valid <= 1'b0;
		rsp_stall <= (stall > 0);
		k = 0;
		do begin
			if (k > 0)
				@(posedge clk);
			if (k > 0 && k == stall)
				rsp_stall <= 1'b0;
			@(negedge clk);
			if (++k > 6000)
				give_up("done");
		end while (done !== 1'b1);
		ok = done_ok;
		rd = done_data;
	endtask
	// Raw frame to the second tag; flip spoils the check byte
	task automatic raw(input logic [7:0] q[$], input logic [7:0] flip);
		int k;
		q.push_back(crc_f(q) ^ flip);
		got.delete();
		foreach (q[i]) begin
			@(posedge clk);
			link_x.cmd_valid <= 1'b1;
			link_x.cmd_data <= q[i];
			link_x.cmd_last <= (i == q.size() - 1);
			k = 0;
			@(negedge clk);
			while (link_x.cmd_ready !== 1'b1) begin
				if (++k > 500)
					give_up("cmd_ready");
				@(negedge clk);
			end
		end
		@(posedge clk);
		link_x.cmd_valid <= 1'b0;
		repeat (400) begin
			@(negedge clk);
			if (link_x.rsp_valid === 1'b1)
				got.push_back({6'h00, link_x.rsp_kind, link_x.rsp_data});
		end
	endtask
	initial begin
		// Raw driver signals have this one process as their only driver
		link_x.cmd_valid <= 1'b0;
		link_x.cmd_data <= 8'h00;
		link_x.cmd_last <= 1'b0;
		link_x.rsp_ready <= 1'b1;
		do_reset();
		@(negedge clk);
		chk("state", tmch_pkg::TST_READY, st1);
		chk("busy", 1'b0, busy1);
		pulse(1'b0);
		req(tmch_pkg::CODE_SEL_QUIET, 8'h00, '0, 0);
		chk("ok", 1'b1, ok);
		chk("state", tmch_pkg::TST_QUIET, st1);
		req(tmch_pkg::CODE_RD_PAGE, 8'h05, '0, 0);
		chk("ok", 1'b0, ok);
		do_reset();
		pulse(1'b0);
		req(tmch_pkg::CODE_RD_PAGE, 8'h05, '0, 0);
		chk("ok", 1'b0, ok);
		req(tmch_pkg::CODE_WR_PAGE, 8'h05, WP, 0);
		chk("ok", 1'b0, ok);
		pulse(1'b1);
		req(tmch_pkg::CODE_WR_PAGE, 8'h05, WP, 0);
		chk("ok", 1'b1, ok);
		req(tmch_pkg::CODE_RD_PAGE, 8'h05, '0, 100);
		chk("ok", 1'b1, ok);
		chk("page", WP, rd[31:0]);
		req(tmch_pkg::CODE_WR_BLOCK, 8'h3C, WB, 0);
		chk("ok", 1'b1, ok);
		req(tmch_pkg::CODE_WR_BLOCK, 8'h3F, {96'h0, WB2}, 0);
		chk("ok", 1'b1, ok);
		req(tmch_pkg::CODE_RD_BLOCK, 8'h3D, '0, 0);
		chk("ok", 1'b1, ok);
		chk("block", {WB2, WB[95:32]}, rd[95:0]);
		chk("state", tmch_pkg::TST_SEL, st1);
		req(tmch_pkg::CODE_RD_PAGE, 8'h40, '0, 0);
		chk("ok", 1'b0, ok);
		raw({8'h0C, 8'h05}, 8'h01);
		chk("beats", 0, got.size());
		raw({8'h0C, 8'h40}, 8'h00);
		chk("beats", 0, got.size());
		raw({8'h08, 8'h07}, 8'h00);
		chk("ack", {6'h00, tmch_pkg::KIND_ACK, 8'h06}, got[1]);
		raw({8'h11, 8'h22, 8'h33, 8'h44}, 8'h00);
		chk("ack", {6'h00, tmch_pkg::KIND_ACK, 8'h06}, got[1]);
		raw({8'h0C, 8'h07}, 8'h00);
		chk("beats", 6, got.size());
		chk("low", {6'h00, tmch_pkg::KIND_DATA, 8'h11}, got[1]);
		chk("crc", {6'h00, tmch_pkg::KIND_DATA,
			crc_f({8'h11, 8'h22, 8'h33, 8'h44})}, got[5]);
		raw({8'h07, 8'h02}, 8'h00);
		chk("sof", {6'h00, tmch_pkg::KIND_SOF, 8'h0A}, got[0]);
		chk("state", tmch_pkg::TST_QUIET, st2);
		req(tmch_pkg::CODE_QUIET, 8'h02, '0, 0);
		chk("ok", 1'b1, ok);
		chk("state", tmch_pkg::TST_QUIET, st1);
		report_and_stop();
	end
endmodule

// file: tmch_asserts.sv
// Checker for the link that joins the reader end to the tag end.
// Assumes the testbench instantiates it beside that interface.
`timescale 1ns/1ps
module tmch_asserts (
	// Clock and reset
	input wire logic       clk,
	input wire logic       reset_n,
	// Command stream
	input wire logic       cmd_valid,
	input wire logic       cmd_ready,
	input wire logic [7:0] cmd_data,
	input wire logic       cmd_last,
	// Response stream
	input wire logic       rsp_valid,
	input wire logic       rsp_ready,
	input wire logic [1:0] rsp_kind,
	input wire logic [7:0] rsp_data,
	input wire logic       rsp_last
);
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	logic       eof;
	logic       sof_tk;
	logic       dat_tk;
	logic       wait_sof_q;
	logic [4:0] n_dat_q;
	assign eof = cmd_valid && cmd_ready && cmd_last;
	assign sof_tk = rsp_valid && rsp_ready && rsp_kind == tmch_pkg::KIND_SOF;
	assign dat_tk = rsp_valid && rsp_ready && rsp_kind == tmch_pkg::KIND_DATA;
	// Data beats since the last start beat
	always_ff @(posedge clk) begin
		if (!reset_n || sof_tk)
			n_dat_q <= 5'h00;
		else if (dat_tk)
			n_dat_q <= n_dat_q + 5'h01;
	end
	// A frame ended; its answer, if any, opens with a start beat
	always_ff @(posedge clk) begin
		if (!reset_n || (rsp_valid && rsp_ready))
			wait_sof_q <= 1'b0;
		else if (eof)
			wait_sof_q <= 1'b1;
	end
	a_sof_code: assert property (
		rsp_valid && rsp_kind == tmch_pkg::KIND_SOF
		|-> rsp_data == 8'h0A && !rsp_last)
		else $error("start beat carries wrong symbols");
	a_ack_code: assert property (
		rsp_valid && rsp_kind == tmch_pkg::KIND_ACK
		|-> rsp_data == 8'h06 && rsp_last)
		else $error("acknowledge beat carries wrong symbols");
	a_reply_wait: assert property (
		eof |=> !rsp_valid [*8])
		else $error("answer came before the turn-round time");
	a_sof_first: assert property (
		wait_sof_q && rsp_valid |-> rsp_kind == tmch_pkg::KIND_SOF)
		else $error("answer did not open with a start beat");
	a_sof_follow: assert property (
		sof_tk |-> ##[1:200] (rsp_valid && rsp_kind != tmch_pkg::KIND_SOF))
		else $error("no body beat after the start beat");
	a_data_count: assert property (
		dat_tk && rsp_last |-> n_dat_q inside {5'd4, 5'd8, 5'd12, 5'd16})
		else $error("read answer holds a wrong number of data bytes");
	a_rsp_hold: assert property (
		rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_data)
		&& $stable(rsp_kind) && $stable(rsp_last))
		else $error("stalled answer beat changed");
	a_cmd_hold: assert property (
		cmd_valid && !cmd_ready |=> cmd_valid && $stable(cmd_data)
		&& $stable(cmd_last))
		else $error("refused command beat changed");
	a_reset_idle: assert property (
		$rose(reset_n) |-> cmd_ready && !rsp_valid)
		else $error("link not idle after reset");
endmodule

// file: tmch_link_if.sv
// Air link between reader and tag, modelled as two byte streams.
// Assumes both ends share clk; the testbench instantiates this.
`timescale 1ns/1ps
interface tmch_link_if;
	// Reader to tag command stream
	logic       cmd_valid;
	logic       cmd_ready;
	logic [7:0] cmd_data;
	logic       cmd_last;
	// Tag to reader response stream
	logic       rsp_valid;
	logic       rsp_ready;
	logic [1:0] rsp_kind;
	logic [7:0] rsp_data;
	logic       rsp_last;

	modport tag (
		input  cmd_valid, cmd_data, cmd_last, rsp_ready,
		output cmd_ready, rsp_valid, rsp_kind, rsp_data, rsp_last
	);
	modport reader (
		output cmd_valid, cmd_data, cmd_last, rsp_ready,
		input  cmd_ready, rsp_valid, rsp_kind, rsp_data, rsp_last
	);
endinterface

// file: tmch_pkg.sv
// Shared constants, types and helpers for the transponder command handler.
// Assumes a single 50 MHz clock on both ends of the link model.
package tmch_pkg;

	// Command codes, low nibble of the first command byte
	localparam logic [3:0] CODE_SEL_QUIET = 4'h0;
	localparam logic [3:0] CODE_RD_PAGE   = 4'hC;
	localparam logic [3:0] CODE_RD_BLOCK  = 4'hD;
	localparam logic [3:0] CODE_WR_PAGE   = 4'h8;
	localparam logic [3:0] CODE_WR_BLOCK  = 4'h9;
	localparam logic [3:0] CODE_QUIET     = 4'h7;

	localparam logic [7:0] MAX_PAGE = 8'h3F;
	localparam logic [1:0] ACK_BITS = 2'h1;
	// Start pattern bits, sent Manchester coded
	localparam logic [1:0] SOF_BITS = 2'h3;

	// Response beat kinds
	localparam logic [1:0] KIND_SOF  = 2'h1;
	localparam logic [1:0] KIND_DATA = 2'h2;
	localparam logic [1:0] KIND_ACK  = 2'h3;

	localparam logic [7:0] CRC_POLY = 8'h1D;
	localparam logic [7:0] CRC_INIT = 8'hFF;

	// Timing, in ns, and derived cycle counts (least times round up)
	localparam int CLK_NS        = 20;
	localparam int T_WRESP_NS    = 200;
	localparam int T_PROG_NS     = 4000;
	localparam int T_WSC_NS      = 400;
	localparam int T_RSP_TO_NS   = 20000;
	localparam int WRESP_CYC     = (T_WRESP_NS + CLK_NS - 1) / CLK_NS;
	localparam int PROG_CYC      = (T_PROG_NS + CLK_NS - 1) / CLK_NS;
	localparam int WSC_CYC       = (T_WSC_NS + CLK_NS - 1) / CLK_NS;
	localparam int RSP_TO_CYC    = T_RSP_TO_NS / CLK_NS;

	typedef enum logic [1:0] {
		TST_READY = 2'b00,
		TST_INIT  = 2'b01,
		TST_SEL   = 2'b10,
		TST_QUIET = 2'b11
	} tmch_tst_t;

	function automatic logic [7:0] crc8(input logic [7:0] crc,
		input logic [7:0] din);
		logic [7:0] c;
		c = crc ^ din;
		for (int i = 0; i < 8; i++) begin
			c = c[7] ? ({c[6:0], 1'b0} ^ CRC_POLY) : {c[6:0], 1'b0};
		end
		return c;
	endfunction

	// Two bits to four half-bit symbols, first bit in the high pair
	function automatic logic [3:0] man2(input logic [1:0] b);
		return {b[1] ? 2'b10 : 2'b01, b[0] ? 2'b10 : 2'b01};
	endfunction

endpackage

// file: tmch_reader.sv
// Reader end: frames user requests, collects and checks tag answers.
// Assumes the tag end of tmch_link_if on the same clock.
`timescale 1ns/1ps

module tmch_reader (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         reset_n,
	// Air link, reader end
	tmch_link_if.reader       link,
	// Request from user
	input  wire logic         req_valid,
	output logic              req_ready,
	input  wire logic [3:0]   req_code,
	input  wire logic [7:0]   req_page_address,
	input  wire logic [31:0]  req_uid,
	input  wire logic [127:0] req_wdata,
	// Result to user
	input  wire logic         rsp_stall,
	output logic              done,
	output logic              done_ok,
	output logic [127:0]      done_data
);
	typedef enum logic [1:0] {
		R_IDLE = 2'b00,
		R_SEND = 2'b01,
		R_RSP  = 2'b10,
		R_WSC  = 2'b11
	} tmch_rst_t;

	tmch_rst_t    st_q;
	logic [3:0]   code_q;
	logic [7:0]   adr_q;
	logic [31:0]  uid_q;
	logic [127:0] wdat_q;
	logic [2:0]   idx_q;
	logic [7:0]   crc_q;
	logic         wph_q;
	logic [2:0]   left_q;
	logic [1:0]   pg_q;
	logic [15:0]  tmr_q;
	logic [127:0] rdat_q;
	logic [4:0]   rcnt_q;
	logic [7:0]   rcrc_q;

	wire is_sq   = code_q == tmch_pkg::CODE_SEL_QUIET;
	wire is_wr   = code_q == tmch_pkg::CODE_WR_PAGE
		|| code_q == tmch_pkg::CODE_WR_BLOCK;
	wire [2:0] flen  = wph_q ? 3'd4 : is_sq ? 3'd5 : 3'd2;
	wire [31:0] wpage = wdat_q[{pg_q, 5'b00000} +: 32];
	wire [1:0]  ui    = idx_q[1:0] - 2'd1;
	wire [7:0]  fbyte = wph_q ? wpage[{idx_q[1:0], 3'b000} +: 8]
		: is_sq ? ((idx_q == 3'd0) ? 8'h00 : uid_q[{ui, 3'b000} +: 8])
		: (idx_q == 3'd0) ? {4'h0, code_q} : adr_q;
	wire send  = link.cmd_valid && link.cmd_ready;
	wire flast = idx_q == flen;
	wire rbeat = link.rsp_valid && link.rsp_ready;
	wire rend  = rbeat && link.rsp_last;
	wire ackv  = link.rsp_kind == tmch_pkg::KIND_ACK
		&& link.rsp_data[3:0] == tmch_pkg::man2(tmch_pkg::ACK_BITS);
	wire datv  = link.rsp_kind == tmch_pkg::KIND_DATA
		&& rcrc_q == link.rsp_data;
	wire tmo   = tmr_q == 16'(tmch_pkg::RSP_TO_CYC - 1);
	wire bad   = !(req_code == tmch_pkg::CODE_SEL_QUIET)
		&& req_page_address > tmch_pkg::MAX_PAGE;

	assign req_ready      = st_q == R_IDLE;
	assign link.cmd_valid = st_q == R_SEND;
	assign link.cmd_last  = flast;
	assign link.cmd_data  = flast ? crc_q : fbyte;
	assign link.rsp_ready = !rsp_stall;

	always_ff @(posedge clk) begin
		if (!reset_n || st_q != R_SEND) begin
			idx_q <= '0;
			crc_q <= tmch_pkg::CRC_INIT;
		end else if (send) begin
			idx_q <= idx_q + 3'd1;
			crc_q <= tmch_pkg::crc8(crc_q, fbyte);
		end
	end

	// Answer collection; the final data beat is the CRC
	always_ff @(posedge clk) begin
		if (!reset_n || (rbeat && link.rsp_kind == tmch_pkg::KIND_SOF)) begin
			rcnt_q <= '0;
			rcrc_q <= tmch_pkg::CRC_INIT;
		end else if (rbeat && link.rsp_kind == tmch_pkg::KIND_DATA
			&& !link.rsp_last) begin
			if (rcnt_q < 5'd16) begin
				rdat_q[{rcnt_q[3:0], 3'b000} +: 8] <= link.rsp_data;
			end
			rcnt_q <= rcnt_q + 5'd1;
			rcrc_q <= tmch_pkg::crc8(rcrc_q, link.rsp_data);
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			st_q      <= R_IDLE;
			wph_q     <= 1'b0;
			left_q    <= '0;
			pg_q      <= '0;
			tmr_q     <= '0;
			done      <= 1'b0;
			done_ok   <= 1'b0;
			done_data <= '0;
			code_q    <= '0;
			adr_q     <= '0;
			uid_q     <= '0;
			wdat_q    <= '0;
		end else begin
			done  <= 1'b0;
			tmr_q <= tmr_q + 16'd1;
			case (st_q)
				R_IDLE: begin
					wph_q <= 1'b0;
					pg_q  <= '0;
					if (req_valid && bad) begin
						done    <= 1'b1;
						done_ok <= 1'b0;
					end else if (req_valid) begin
						code_q <= req_code;
						adr_q  <= req_page_address;
						uid_q  <= req_uid;
						wdat_q <= req_wdata;
						// pages from address to block end
						left_q <= (req_code == tmch_pkg::CODE_WR_BLOCK)
							? 3'd4 - {1'b0, req_page_address[1:0]} : 3'd1;
						st_q   <= R_SEND;
					end
				end
				R_SEND: begin
					tmr_q <= '0;
					if (send && flast) begin
						st_q <= R_RSP;
					end
				end
				R_RSP: begin
					if (rend && is_wr && ackv && (!wph_q || left_q != 3'd1))
						begin
						if (wph_q) begin
							left_q <= left_q - 3'd1;
							pg_q   <= pg_q + 2'd1;
						end
						wph_q <= 1'b1;
						tmr_q <= '0;
						st_q  <= R_WSC;
					end else if (rend || tmo) begin
						done      <= 1'b1;
						done_ok   <= rend && (ackv || datv);
						done_data <= rdat_q;
						st_q      <= R_IDLE;
					end
				end
				R_WSC: begin
					if (tmr_q == 16'(tmch_pkg::WSC_CYC - 1)) begin
						st_q <= R_SEND;
					end
				end
				default: st_q <= R_IDLE;
			endcase
		end
	end
endmodule

// file: tmch_tag.sv
// Tag end: command interpreter, page memory and response buffer.
// Assumes select and init are decided by logic outside this file.
// Function
// - Select-quiet with own UID in init: quiet
// - SOF and acknowledge sent Manchester coded
// - Reads only when selected
// - Page read replies SOF, 32 bits, CRC
// - Reader keeps page address at most 0x3F
// - Block read sends to block end
// - Writes only selected; low byte first
// - Page write command acknowledged
// - Reader waits set-up, sends page and CRC
// - Program page, then acknowledge
// - Block write command acknowledged
// - Reader sends pages singly to block end
// - Acknowledge each programmed block page
// - Quiet command in selected: quiet, acknowledge
// - Quiet carries address and CRC for structure
// - Quiet tag answers nothing until power loss
// - One selected tag, plain transfers
`timescale 1ns/1ps

module tmch_buf #(
	parameter int W     = 11,
	parameter int DEPTH = 2
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         reset_n,
	// Fill side
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	// Drain side
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [W-1:0] mem_q [DEPTH];
	logic [AW-1:0] wp_q;
	logic [AW-1:0] rp_q;
	logic [AW:0]   cnt_q;

	wire push = in_valid && in_ready;
	wire pop  = out_valid && out_ready;

	assign in_ready  = cnt_q != (AW+1)'(DEPTH);
	assign out_valid = cnt_q != '0;
	assign out_data  = mem_q[rp_q];

	always_ff @(posedge clk) begin
		if (push) begin
			mem_q[wp_q] <= in_data;
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			wp_q  <= '0;
			rp_q  <= '0;
			cnt_q <= '0;
		end else begin
			if (push) begin
				wp_q <= (wp_q == AW'(DEPTH - 1)) ? '0 : wp_q + 1'b1;
			end
			if (pop) begin
				rp_q <= (rp_q == AW'(DEPTH - 1)) ? '0 : rp_q + 1'b1;
			end
			cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

module tmch_tag #(
	parameter int PAGES = 64
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             reset_n,
	// Air link, tag end
	tmch_link_if.tag              link,
	// Identity and state steering from the select logic
	input  wire logic [31:0]      uid,
	input  wire logic             go_init,
	input  wire logic             go_select,
	// Status
	output tmch_pkg::tmch_tst_t   tag_state,
	output logic                  busy
);
	localparam int AW = $clog2(PAGES);
	localparam int NB = 7;

	typedef enum logic [1:0] {
		P_RX   = 2'b00,
		P_WAIT = 2'b01,
		P_PROG = 2'b10,
		P_TX   = 2'b11
	} tmch_proc_t;

	tmch_pkg::tmch_tst_t tst_q;
	tmch_proc_t  proc_q;
	logic [7:0]  rx_buf_q [NB];
	logic [2:0]  rx_cnt_q;
	logic [7:0]  rx_crc_q;
	logic        wph_q;
	logic [2:0]  wleft_q;
	logic [AW-1:0] page_q;
	logic [2:0]  npg_q;
	logic        tx_ack_q;
	logic [4:0]  tx_idx_q;
	logic [7:0]  tx_crc_q;
	logic [31:0] wword_q;
	logic [15:0] tmr_q;
	logic [31:0] mem_q [PAGES];

	// Command frame decode
	wire       beat   = link.cmd_valid && link.cmd_ready;
	wire       eof    = beat && link.cmd_last;
	wire [7:0] b0     = rx_buf_q[0];
	wire [7:0] adr    = rx_buf_q[1];
	wire [3:0] code   = b0[3:0];
	wire [31:0] uid_rx = {rx_buf_q[4], rx_buf_q[3], rx_buf_q[2], rx_buf_q[1]};
	// page data arrives low byte first, no leading code byte
	wire [31:0] wd_rx  = {rx_buf_q[3], rx_buf_q[2], rx_buf_q[1], rx_buf_q[0]};
	wire       crc_ok = rx_crc_q == link.cmd_data;
	wire       is_sq  = !wph_q && rx_cnt_q == 3'd5 && b0 == 8'h00
		&& tst_q == tmch_pkg::TST_INIT && uid_rx == uid;
	wire       is_cmd = !wph_q && rx_cnt_q == 3'd2 && b0[7:4] == 4'h0
		&& tst_q == tmch_pkg::TST_SEL && adr <= tmch_pkg::MAX_PAGE;
	wire       is_rd  = is_cmd && (code == tmch_pkg::CODE_RD_PAGE
		|| code == tmch_pkg::CODE_RD_BLOCK);
	wire       is_wr  = is_cmd && (code == tmch_pkg::CODE_WR_PAGE
		|| code == tmch_pkg::CODE_WR_BLOCK);
	wire       is_qt  = is_cmd && code == tmch_pkg::CODE_QUIET;
	wire       is_wd  = wph_q && rx_cnt_q == 3'd4;
	wire       accept = eof && crc_ok && (is_sq || is_rd || is_wr || is_qt
		|| is_wd);
	wire [2:0] to_end = 3'd4 - {1'b0, adr[1:0]};

	// Response beat build
	wire [4:0] di      = tx_idx_q - 5'd1;
	wire [AW-1:0] tpg  = page_q + AW'(di[3:2]);
	wire [31:0] tword  = mem_q[tpg];
	wire [7:0] tbyte   = tword[{di[1:0], 3'b000} +: 8];
	wire [4:0] tx_end  = tx_ack_q ? 5'd1 : {npg_q[2:0], 2'b00} + 5'd1;
	wire       tx_last = tx_idx_q == tx_end;
	wire       tx_sof  = tx_idx_q == 5'd0;
	logic [1:0] tx_kind;
	logic [7:0] tx_data;
	logic       tx_in_ready;
	wire       tx_take = proc_q == P_TX && tx_in_ready;

	assign tx_kind = tx_sof ? tmch_pkg::KIND_SOF
		: tx_ack_q ? tmch_pkg::KIND_ACK : tmch_pkg::KIND_DATA;
	assign tx_data = tx_sof ? {4'h0, tmch_pkg::man2(tmch_pkg::SOF_BITS)}
		: tx_ack_q ? {4'h0, tmch_pkg::man2(tmch_pkg::ACK_BITS)}
		: tx_last ? tx_crc_q : tbyte;

	assign link.cmd_ready = proc_q == P_RX;
	assign tag_state      = tst_q;
	assign busy           = proc_q != P_RX;

	// A stalled reader fills this buffer and then holds the sequencer
	tmch_buf #(
		.W     (11),
		.DEPTH (2)
	) u_txbuf (
		.clk       (clk),
		.reset_n   (reset_n),
		.in_valid  (proc_q == P_TX),
		.in_ready  (tx_in_ready),
		.in_data   ({tx_kind, tx_last, tx_data}),
		.out_valid (link.rsp_valid),
		.out_ready (link.rsp_ready),
		.out_data  ({link.rsp_kind, link.rsp_last, link.rsp_data})
	);

	// Command byte capture; the CRC byte itself is compared, not stored
	always_ff @(posedge clk) begin
		if (beat && !link.cmd_last && rx_cnt_q < 3'(NB)) begin
			rx_buf_q[rx_cnt_q] <= link.cmd_data;
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n || eof) begin
			rx_cnt_q <= '0;
			rx_crc_q <= tmch_pkg::CRC_INIT;
		end else if (beat) begin
			rx_cnt_q <= (rx_cnt_q == 3'h7) ? rx_cnt_q : rx_cnt_q + 3'd1;
			rx_crc_q <= tmch_pkg::crc8(rx_crc_q, link.cmd_data);
		end
	end

	// only the select logic promotes to selected
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			tst_q <= tmch_pkg::TST_READY;
		end else if (accept && (is_sq || is_qt)) begin
			tst_q <= tmch_pkg::TST_QUIET;
		end else if (go_init && tst_q == tmch_pkg::TST_READY) begin
			tst_q <= tmch_pkg::TST_INIT;
		end else if (go_select && tst_q == tmch_pkg::TST_INIT) begin
			tst_q <= tmch_pkg::TST_SEL;
		end
	end

	always_ff @(posedge clk) begin
		if (proc_q == P_PROG && tmr_q == 16'(tmch_pkg::PROG_CYC - 1)) begin
			mem_q[page_q] <= wword_q;
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			proc_q   <= P_RX;
			wph_q    <= 1'b0;
			wleft_q  <= '0;
			page_q   <= '0;
			npg_q    <= 3'd1;
			tx_ack_q <= 1'b1;
			wword_q  <= '0;
			tmr_q    <= '0;
		end else begin
			tmr_q <= tmr_q + 16'd1;
			case (proc_q)
				P_RX: begin
					tmr_q <= '0;
					if (accept) begin
						tx_ack_q <= !is_rd;
						if (is_wd) begin
							wword_q <= wd_rx;
							wleft_q <= wleft_q - 3'd1;
							proc_q  <= P_PROG;
						end else begin
							page_q <= adr[AW-1:0];
							npg_q  <= (code == tmch_pkg::CODE_RD_BLOCK)
								? to_end : 3'd1;
							wleft_q <= (code == tmch_pkg::CODE_WR_BLOCK)
								? to_end : 3'd1;
							proc_q  <= P_WAIT;
						end
					end else if (eof) begin
						wph_q <= 1'b0;
					end
				end
				P_WAIT: begin
					if (tmr_q == 16'(tmch_pkg::WRESP_CYC - 1)) begin
						proc_q <= P_TX;
					end
				end
				P_PROG: begin
					if (tmr_q == 16'(tmch_pkg::PROG_CYC - 1)) begin
						page_q <= page_q + 1'b1;
						proc_q <= P_TX;
					end
				end
				P_TX: begin
					if (tx_take && tx_last) begin
						wph_q  <= tx_ack_q && wleft_q != 3'd0
							&& tst_q == tmch_pkg::TST_SEL;
						proc_q <= P_RX;
					end
				end
				default: proc_q <= P_RX;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n || proc_q != P_TX) begin
			tx_idx_q <= '0;
			tx_crc_q <= tmch_pkg::CRC_INIT;
		end else if (tx_take) begin
			tx_idx_q <= tx_idx_q + 5'd1;
			if (!tx_sof && !tx_last) begin
				tx_crc_q <= tmch_pkg::crc8(tx_crc_q, tbyte);
			end
		end
	end
endmodule
